/* File: src/serial_port_defines.vh */
// Purpose: Constants for the multi-mode serial port
// Assumes: 10 MHz system clock
// Notes:   Byte addresses on a 32-bit Avalon-MM slave
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH
// ==========================================================
// Register map
`define ADDR_DATA  4'h0
`define ADDR_CTRL  4'h4
`define ADDR_DIV   4'h8
`define ADDR_STAT  4'hC
// ==========================================================
// Control fields
`define CTL_MODE_LO 0
`define CTL_MODE_HI 1
`define CTL_LEN7    2
`define CTL_NINTH   3
`define CTL_EXTCLK  4
`define CTL_IRDA    5
`define CTL_SSEL_LO 6
`define CTL_SSEL_HI 7
`define CTL_GPO     8
`define CTL_RESET   9'h000
`define DAT_FLAG    9
`define STA_OVR     2
// ==========================================================
// Modes
`define MODE_ASYNC 2'h0
`define MODE_SYNC  2'h1
`define MODE_SDLC  2'h2
`define SSEL_FETCH 2'h0
`define SSEL_IACK  2'h1
`define SSEL_GPO   2'h2
// Boot encoding {pin0, pin1}
`define BOOT_RUN   2'h0
`define BOOT_SLAVE 2'h1
`define BOOT_SYNCA 2'h2
`define BOOT_ASYNA 2'h3
`define START_ADDR 16'h0000
// ==========================================================
// Timing
`define CLK_HZ     10000000
`define BOOT_BAUD  2400
`define OVERSAMPLE 16
`define BOOT_DIV   (`CLK_HZ / (`OVERSAMPLE * `BOOT_BAUD))
`define DIV_RESET  16'h0001
// Internal shift clock: bit time >= 128 / 0.80 clocks
`define SYNC_DIVN  128
`define SYNC_PCT   80
`define SYNC_HALF  ((`SYNC_DIVN * 100 + 2 * `SYNC_PCT - 1) / (2 * `SYNC_PCT))
`define PH_LAST    4'hF
`define PH_MID     4'h7
`define IR_PULSE   4'h3
`define FLAG_BYTE  8'h7E
`define STUFF_RUN  3'h5
`define FLAG_RUN   3'h6
`endif

/* File: src/serial_port.v */
// Purpose: Multi-mode serial port with boot-mode capture and status pin
// Assumes: Avalon-MM slave, one wait state per access; same-clock
//          fetch/acknowledge strobes; pins synchronised here
// Notes:   Contract
// Contract
// - Async mode reaches system clock divided by sixteen.
// - Async character carries seven or eight data bits.
// - Optional ninth bit marks first byte of a message.
// - Clocked mode shifts each bit with a dedicated clock line.
// - Either this port or the partner drives the clock, never both.
// - Own clock bit rate at most 80% of clock over 128.
// - HDLC framing with stuffing, and IrDA pulses in that format.
// - Clock pin stays readable as an input in async mode.
// - Sample startup pins after reset; cold boot or run at zero.
// - Cable holds both pins high for program, low for run.
// - Status pin pulses on fetch, on acknowledge, or is an output.
// - Pin pairs select run, slave, clocked or 2400 bps async boot.
`include "serial_port_defines.vh"
module serial_port
(
    // Clock and reset
    input  wire        clk,
    input  wire        nrst,
    // Avalon-MM slave
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Serial line
    input  wire        rxd,
    output reg         txd,
    output reg         irda_tx,
    input  wire        sclk_i,
    output reg         sclk_o,
    output wire        sclk_oe_n,
    // Startup mode pins
    input  wire        startup_mode_pin_0,
    input  wire        startup_mode_pin_1,
    output reg         boot_valid,
    output reg  [1:0]  boot_mode,
    output reg         cold_boot,
    output reg  [15:0] start_addr,
    // Processor status
    input  wire        first_fetch,
    input  wire        int_ack,
    output reg         status_n
);
// ==========================================================
// Pin synchronisers
reg        rxd_s1, rxd_q, rxd_p;
reg        sck_s1, sck_q;
reg  [1:0] sm_s1, sm_q;
always @(posedge clk)
begin
    if (!nrst)
    begin
        rxd_s1 <= 1'b1;
        rxd_q  <= 1'b1;
        rxd_p  <= 1'b1;
        sck_s1 <= 1'b1;
        sck_q  <= 1'b1;
        sm_s1  <= 2'h0;
        sm_q   <= 2'h0;
    end
    else
    begin
        rxd_s1 <= rxd;
        rxd_q  <= rxd_s1;
        rxd_p  <= rxd_q;
        sck_s1 <= sclk_i;
        sck_q  <= sck_s1;
        sm_s1  <= {startup_mode_pin_0, startup_mode_pin_1};
        sm_q   <= sm_s1;
    end
end
// ==========================================================
// Registers and bus
reg  [8:0]  ctrl_q;
reg  [15:0] div_q;
reg         ack_q;
reg  [8:0]  rx_data_q;
reg         rx_full_q, rx_ovr_q, tx_busy_q, rx_flag_q;
reg  [1:0]  boot_cnt_q;
wire [31:0] boot_div_w  = `BOOT_DIV;
wire [31:0] sync_half_w = `SYNC_HALF;
wire [1:0]  mode   = ctrl_q[`CTL_MODE_HI:`CTL_MODE_LO];
wire        m_sync = (mode == `MODE_SYNC);
wire        m_sdlc = (mode == `MODE_SDLC);
wire        len7   = ctrl_q[`CTL_LEN7];
wire        nin_en = ctrl_q[`CTL_NINTH];
wire        extclk = ctrl_q[`CTL_EXTCLK];
wire        rd_en  = avs_read & ack_q;
wire        wr_en  = avs_write & ack_q;
wire        wr_dat = wr_en & (avs_address == `ADDR_DATA);
wire        rd_dat = rd_en & (avs_address == `ADDR_DATA);
wire        wr_sta = wr_en & (avs_address == `ADDR_STAT);
assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
// Partner clock enters only while the pin is released
assign sclk_oe_n = ~(m_sync & ~extclk);
always @(posedge clk)
begin
    if (!nrst)
    begin
        ack_q        <= 1'b0;
        avs_readdata <= 32'h0000_0000;
        ctrl_q       <= `CTL_RESET;
        div_q        <= `DIV_RESET;
        boot_cnt_q   <= 2'h0;
        boot_valid   <= 1'b0;
        boot_mode    <= `BOOT_RUN;
        cold_boot    <= 1'b0;
        start_addr   <= `START_ADDR;
    end
    else
    begin
        ack_q <= (avs_read | avs_write) & ~ack_q;
        if (avs_read & ~ack_q)
        begin
            case (avs_address)
            `ADDR_DATA: avs_readdata <= {23'h0, rx_data_q};
            `ADDR_CTRL: avs_readdata <= {23'h0, ctrl_q};
            `ADDR_DIV:  avs_readdata <= {16'h0, div_q};
            // Clock pin level kept visible in every mode
            `ADDR_STAT: avs_readdata <= {25'h0, boot_mode, rx_flag_q,
                             sck_q, rx_ovr_q, rx_full_q, tx_busy_q};
            default:    avs_readdata <= 32'h0000_0000;
            endcase
        end
        if (wr_en & (avs_address == `ADDR_CTRL))
            ctrl_q <= avs_writedata[8:0];
        if (wr_en & (avs_address == `ADDR_DIV))
            div_q <= avs_writedata[15:0];
        // Pins are captured three edges after release, once sync settles
        if (!boot_valid)
            boot_cnt_q <= boot_cnt_q + 2'h1;
        if (!boot_valid && boot_cnt_q == 2'h2)
        begin
            boot_valid <= 1'b1;
            boot_mode  <= sm_q;
            cold_boot  <= (sm_q != `BOOT_RUN);
            start_addr <= `START_ADDR;
            if (sm_q == `BOOT_ASYNA)
            begin
                ctrl_q <= `CTL_RESET;
                div_q  <= boot_div_w[15:0];
            end
            else if (sm_q == `BOOT_SYNCA)
                ctrl_q <= {7'h00, `MODE_SYNC} | 9'h010;
        end
    end
end
// ==========================================================
// Bit rate generators
reg  [15:0] tcnt_q, hcnt_q;
reg         sck_gen_q, sc_prev_q;
wire [15:0] div_m1 = (div_q == 16'h0) ? 16'h0 : div_q - 16'h1;
wire        tick   = (tcnt_q >= div_m1);
wire [15:0] half   = (div_q < sync_half_w[15:0]) ? sync_half_w[15:0]
                                                 : div_q;
wire        sc     = extclk ? sck_q : sck_gen_q;
wire        s_rise = m_sync & sc & ~sc_prev_q;
wire        s_fall = m_sync & ~sc & sc_prev_q;
always @(posedge clk)
begin
    if (!nrst)
    begin
        tcnt_q    <= 16'h0;
        hcnt_q    <= 16'h0;
        sck_gen_q <= 1'b1;
        sc_prev_q <= 1'b1;
        sclk_o    <= 1'b1;
    end
    else
    begin
        tcnt_q    <= tick ? 16'h0 : tcnt_q + 16'h1;
        sc_prev_q <= sc;
        sclk_o    <= sck_gen_q;
        // Divider stays on the system clock; no derived clock domain
        if (!m_sync || extclk || !tx_busy_q)
        begin
            hcnt_q    <= 16'h0;
            sck_gen_q <= 1'b1;
        end
        else if (hcnt_q >= half - 16'h1)
        begin
            hcnt_q    <= 16'h0;
            sck_gen_q <= ~sck_gen_q;
        end
        else
            hcnt_q <= hcnt_q + 16'h1;
    end
end
// ==========================================================
// Transmitter
reg  [10:0] tx_sh_q;
reg  [3:0]  tx_left_q, tph_q;
reg  [2:0]  ones_q;
reg         tx_flag_q;
wire        nin_bit = nin_en ? avs_writedata[8] : 1'b1;
wire [9:0]  body = len7 ? {2'h3, nin_bit, avs_writedata[6:0]}
                        : {1'b1, nin_bit, avs_writedata[7:0]};
wire [3:0]  nbits = (len7 ? 4'h9 : 4'hA) + {3'h0, nin_en};
wire        dflag = avs_writedata[`DAT_FLAG];
wire [7:0]  sbyte = dflag ? `FLAG_BYTE : avs_writedata[7:0];
wire        tx_adv = m_sync ? (s_fall | s_rise)
                            : (tick & (tph_q == `PH_LAST));
wire [2:0]  ones_n = txd ? ones_q + 3'h1 : 3'h0;
always @(posedge clk)
begin
    if (!nrst)
    begin
        tx_sh_q   <= 11'h7FF;
        tx_left_q <= 4'h0;
        tph_q     <= 4'h0;
        ones_q    <= 3'h0;
        tx_flag_q <= 1'b0;
        tx_busy_q <= 1'b0;
        txd       <= 1'b1;
        irda_tx   <= 1'b0;
    end
    else
    begin
        irda_tx <= ctrl_q[`CTL_IRDA] & m_sdlc & tx_busy_q & ~txd
                   & (tph_q < `IR_PULSE);
        if (tick)
            tph_q <= tph_q + 4'h1;
        if (wr_dat & ~tx_busy_q)
        begin
            tx_busy_q <= 1'b1;
            tph_q     <= 4'h0;
            tx_flag_q <= dflag & m_sdlc;
            if (dflag & m_sdlc)
                ones_q <= 3'h0;
            if (mode == `MODE_ASYNC)
            begin
                tx_sh_q   <= {body, 1'b0};
                tx_left_q <= nbits;
                txd       <= 1'b0;
            end
            else
            begin
                tx_sh_q   <= {3'h7, sbyte};
                tx_left_q <= 4'h8;
                txd       <= sbyte[0];
            end
        end
        else if (tx_busy_q & tx_adv)
        begin
            // Clocked: new bit on each fall, done on the eighth rise so
            // the line clock parks high with no short last phase
            if (m_sync & s_rise)
            begin
                if (tx_left_q == 4'h1)
                    tx_busy_q <= 1'b0;
                tx_left_q <= tx_left_q - 4'h1;
            end
            else if (m_sync)
            begin
                tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                txd     <= tx_sh_q[0];
            end
            else if (m_sdlc & ~tx_flag_q & (ones_n == `STUFF_RUN))
            begin
                txd    <= 1'b0;
                ones_q <= 3'h0;
            end
            else if (tx_left_q == 4'h1)
            begin
                tx_busy_q <= 1'b0;
                txd       <= 1'b1;
                ones_q    <= ones_n;
            end
            else
            begin
                tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                txd       <= tx_sh_q[1];
                tx_left_q <= tx_left_q - 4'h1;
                ones_q    <= ones_n;
            end
        end
    end
end
// ==========================================================
// Receiver
reg  [8:0] rx_sh_q;
reg  [3:0] rx_cnt_q, rph_q;
reg  [2:0] rones_q;
reg        rx_act_q;
wire       r_edge = rxd_q ^ rxd_p;
wire       r_samp = tick & (rph_q == `PH_MID) & ~m_sync;
wire [8:0] nsh    = {rxd_q, rx_sh_q[8:1]};
wire [3:0] k_a    = (len7 ? 4'h7 : 4'h8) + {3'h0, nin_en};
wire [8:0] dv_a   = rx_sh_q >> (4'h9 - k_a);
wire [8:0] dv_x   = len7 ? {1'b0, nin_en & dv_a[7], dv_a[6:0]}
                         : {nin_en & dv_a[8], dv_a[7:0]};
reg        dlv;
reg  [8:0] dlv_val;
always @*
begin
    dlv     = 1'b0;
    dlv_val = {1'b0, nsh[8:1]};
    if (s_rise & (rx_cnt_q == 4'h7))
        dlv = 1'b1;
    else if (r_samp & m_sdlc & rxd_q & (rx_cnt_q == 4'h7))
        dlv = 1'b1;
    else if (r_samp & m_sdlc & ~rxd_q & (rones_q < `STUFF_RUN)
             & (rx_cnt_q == 4'h7))
        dlv = 1'b1;
    else if (r_samp & rx_act_q & (mode == `MODE_ASYNC)
             & (rx_cnt_q == k_a + 4'h1))
    begin
        dlv     = 1'b1;
        dlv_val = dv_x;
    end
end
always @(posedge clk)
begin
    if (!nrst)
    begin
        rx_sh_q   <= 9'h000;
        rx_cnt_q  <= 4'h0;
        rph_q     <= 4'h0;
        rones_q   <= 3'h0;
        rx_act_q  <= 1'b0;
        rx_data_q <= 9'h000;
        rx_full_q <= 1'b0;
        rx_ovr_q  <= 1'b0;
        rx_flag_q <= 1'b0;
    end
    else
    begin
        // Edge resync keeps the mid-bit sample centred
        rph_q <= r_edge ? 4'h0 : (tick ? rph_q + 4'h1 : rph_q);
        if (dlv)
        begin
            rx_data_q <= dlv_val;
            rx_cnt_q  <= 4'h0;
            rx_act_q  <= 1'b0;
        end
        // Set wins over the clearing read or write
        rx_full_q <= dlv | (rx_full_q & ~rd_dat);
        rx_ovr_q  <= (dlv & rx_full_q)
                     | (rx_ovr_q & ~(wr_sta & avs_writedata[`STA_OVR]));
        // Clear sits before the flag detector so a same-cycle flag wins
        if (wr_sta & avs_writedata[3])
            rx_flag_q <= 1'b0;
        if (m_sync)
        begin
            if (s_rise & ~dlv)
            begin
                rx_sh_q  <= nsh;
                rx_cnt_q <= rx_cnt_q + 4'h1;
            end
        end
        else if (m_sdlc)
        begin
            if (r_samp)
            begin
                rones_q <= rxd_q ? rones_q + 3'h1 : 3'h0;
                if (~rxd_q & (rones_q == `FLAG_RUN))
                begin
                    rx_cnt_q  <= 4'h0;
                    rx_flag_q <= 1'b1;
                end
                else if (~rxd_q & (rones_q == `STUFF_RUN))
                    rx_cnt_q <= rx_cnt_q;
                else if (~dlv)
                begin
                    rx_sh_q  <= nsh;
                    rx_cnt_q <= rx_cnt_q + 4'h1;
                end
            end
        end
        else if (!rx_act_q)
        begin
            if (r_edge & ~rxd_q)
            begin
                rx_act_q <= 1'b1;
                rx_cnt_q <= 4'h0;
            end
        end
        else if (r_samp & ~dlv)
        begin
            if ((rx_cnt_q == 4'h0) & rxd_q)
                rx_act_q <= 1'b0;
            else
            begin
                if (rx_cnt_q != 4'h0)
                    rx_sh_q <= nsh;
                rx_cnt_q <= rx_cnt_q + 4'h1;
            end
        end
    end
end
// ==========================================================
// Status pin
always @(posedge clk)
begin
    if (!nrst)
        status_n <= 1'b1;
    else
    begin
        case (ctrl_q[`CTL_SSEL_HI:`CTL_SSEL_LO])
        `SSEL_FETCH: status_n <= ~first_fetch;
        `SSEL_IACK:  status_n <= ~int_ack;
        `SSEL_GPO:   status_n <= ctrl_q[`CTL_GPO];
        default:     status_n <= 1'b1;
        endcase
    end
end
endmodule // serial_port

/* File: tb/serial_port_monitor.sv */
// Purpose: Port-level checks of the serial port
// Assumes: Control copy is rebuilt from accepted bus writes
// Notes:   Boot overrides of control are not mirrored here
`include "serial_port_defines.vh"
// ==========================================
// Checker
module serial_port_monitor
(
    // Clock and reset
    input logic        clk,
    input logic        nrst,
    // Bus
    input logic [3:0]  avs_address,
    input logic        avs_write,
    input logic [31:0] avs_writedata,
    input logic        avs_waitrequest,
    // Pins
    input logic        txd,
    input logic        irda_tx,
    input logic        sclk_o,
    input logic        sclk_oe_n,
    input logic        startup_mode_pin_0,
    input logic        startup_mode_pin_1,
    input logic        boot_valid,
    input logic [1:0]  boot_mode,
    input logic        cold_boot,
    input logic [15:0] start_addr,
    input logic        first_fetch,
    input logic        int_ack,
    input logic        status_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] ctl_q;
    logic [7:0] cnt_q;
    logic       prv_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Counter saturates so a long idle never looks like a short half
    always_ff @(posedge clk)
    begin
        prv_q <= sclk_o;
        if (!nrst)
        begin
            ctl_q <= `CTL_RESET;
            cnt_q <= 8'hFF;
        end
        else
        begin
            if (avs_write && !avs_waitrequest && avs_address == `ADDR_CTRL)
                ctl_q <= avs_writedata[8:0];
            if (sclk_o != prv_q)
                cnt_q <= 8'h01;
            else if (cnt_q != 8'hFF)
                cnt_q <= cnt_q + 8'h01;
        end
    end
    rst_idle_a:
        assert property (disable iff (1'h0) !nrst |=> txd && sclk_o
            && sclk_oe_n && status_n && !boot_valid) else $error("idle");
    oe_own_a:
        assert property (!sclk_oe_n |-> ctl_q[1:0] == `MODE_SYNC
            && !ctl_q[`CTL_EXTCLK]) else $error("clock drive");
    half_min_a:
        assert property (sclk_o != prv_q && !sclk_oe_n
            |-> cnt_q >= `SYNC_HALF) else $error("clock too fast");
    fetch_pulse_a:
        assert property (ctl_q[7:6] == `SSEL_FETCH && first_fetch
            |=> !status_n) else $error("no fetch pulse");
    iack_pulse_a:
        assert property (ctl_q[7:6] == `SSEL_IACK && int_ack
            |=> !status_n) else $error("no ack pulse");
    fetch_idle_a:
        assert property (ctl_q[7:6] == `SSEL_FETCH && !first_fetch
            |=> status_n) else $error("stray pulse");
    gpo_level_a:
        assert property (ctl_q[7:6] == `SSEL_GPO && $stable(ctl_q)
            |-> status_n == ctl_q[`CTL_GPO]) else $error("gpo level");
    boot_code_a:
        assert property ($rose(boot_valid) |-> boot_mode ==
            {startup_mode_pin_0, startup_mode_pin_1}
            && cold_boot == (boot_mode != `BOOT_RUN)
            && start_addr == `START_ADDR) else $error("boot code");
    irda_gate_a:
        assert property (irda_tx |-> !txd && ctl_q[`CTL_IRDA]
            && ctl_q[1:0] == `MODE_SDLC) else $error("stray ir pulse");
    boot_time_a:
        assert property ($rose(nrst) |-> ##[1:4] boot_valid)
            else $error("boot late");
endmodule // serial_port_monitor

bind serial_port serial_port_monitor mon
(
    .clk, .nrst, .avs_address, .avs_write, .avs_writedata,
    .avs_waitrequest, .txd, .irda_tx, .sclk_o, .sclk_oe_n,
    .startup_mode_pin_0,
    .startup_mode_pin_1, .boot_valid, .boot_mode, .cold_boot,
    .start_addr, .first_fetch, .int_ack, .status_n
);

/* File: tb/serial_peer.sv */
// Purpose: Serial peer on the far side of the port
// Assumes: Sixteen clocks a bit in async mode
// Notes:   Its clock stands high outside frames unless level sets it low
// ==========================================
// Peer model
module serial_peer
(
    // Clock
    input  logic       clk,
    // Line
    input  logic       txd,
    input  logic       sclk_line,
    input  logic       sclk_oe_n,
    output logic       rxd,
    output logic       sclk_drv,
    // Capture
    output logic [7:0] got
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prv;
    initial
    begin
        rxd = 1'h1;
        sclk_drv = 1'h1;
        got = 8'h00;
        prv = 1'h1;
    end
    // Sample on the rise of the port's own clock, LSB first
    always @(posedge clk)
    begin
        prv <= sclk_line;
        if (!sclk_oe_n && sclk_line && !prv)
            got <= {txd, got[7:1]};
    end
    task automatic bit_out(input logic b, input int n);
    begin
        rxd <= b;
        repeat (n) @(posedge clk);
    end
    endtask
    task automatic send_async(input logic [8:0] v);
        int i;
    begin
        bit_out(1'h0, 16);
        for (i = 0; i < 9; i++)
            bit_out(v[i], 16);
        bit_out(1'h1, 16);
    end
    endtask
    task automatic send_sync(input logic [7:0] v);
        int i;
    begin
        for (i = 0; i < 8; i++)
        begin
            sclk_drv <= 1'h0;
            bit_out(v[i], 4);
            sclk_drv <= 1'h1;
            repeat (4) @(posedge clk);
        end
        rxd <= 1'h1;
    end
    endtask
    task automatic level(input logic b);
    begin
        sclk_drv <= b;
    end
    endtask
endmodule // serial_peer

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the serial port
// Assumes: Run-mode boot leaves divider at one
// Notes:   Bus waits end only by the cycle ceiling
`include "serial_port_defines.vh"
// ==========================================
// Bench
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, nrst = 0, rd = 0, wr = 0, p0 = 0, p1 = 0;
    logic        ff = 0, ia = 0;
    logic [3:0]  adr = 0;
    logic [31:0] wd = 0, q;
    logic [7:0]  fl = `FLAG_BYTE;
    logic [9:0]  ctl_t [3] = '{10'h008, 10'h004, 10'h000};
    logic [8:0]  val_t [3] = '{9'h1A5, 9'h05A, 9'h033};
    wire  [31:0] rdata;
    wire  [15:0] sa;
    wire  [7:0]  got;
    wire  [1:0]  bm;
    wire         wreq, rxd, txd, irda, sclk_o, oe_n, bv, cb, st_n, sdrv;
    wire         sclk_i = oe_n ? sdrv : sclk_o;
    int          bad_count = 0, checks = 0, cyc = 0, i;
    serial_port dut
    (
        .clk(clk), .nrst(nrst), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .rxd(rxd), .txd(txd), .irda_tx(irda),
        .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe_n(oe_n),
        .startup_mode_pin_0(p0), .startup_mode_pin_1(p1),
        .boot_valid(bv), .boot_mode(bm), .cold_boot(cb),
        .start_addr(sa), .first_fetch(ff), .int_ack(ia), .status_n(st_n)
    );
    serial_peer peer
    (
        .clk(clk), .txd(txd), .sclk_line(sclk_i), .sclk_oe_n(oe_n),
        .rxd(rxd), .sclk_drv(sdrv), .got(got)
    );
    always #50 clk = !clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            bad_count++;
            end_sim;
        end
    end
    task automatic end_sim;
    begin
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
    begin
        checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    end
    endtask
    // Request held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
    begin
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do
            @(posedge clk);
        while (wreq !== 1'h0);
        q = rdata;
        rd <= 1'h0;
        wr <= 1'h0;
        @(posedge clk);
    end
    endtask
    task automatic do_reset;
    begin
        nrst <= 1'h0;
        repeat (20) @(posedge clk);
        nrst <= 1'h1;
        while (bv !== 1'h1)
            @(posedge clk);
    end
    endtask
    task automatic pulse(input logic f, input logic a, input logic e);
    begin
        ff <= f;
        ia <= a;
        @(posedge clk);
        ff <= 1'h0;
        ia <= 1'h0;
        @(posedge clk);
        chk(st_n, e);
    end
    endtask
    task automatic tx_async(input logic [9:0] c, input logic [8:0] v);
        logic [11:0] fr;
        int          d, k;
    begin
        d = c[`CTL_LEN7] ? 7 : 8;
        fr = 12'hFFF;
        fr[0] = 1'h0;
        for (k = 0; k < d; k++)
            fr[k + 1] = v[k];
        if (c[`CTL_NINTH])
            fr[d + 1] = v[8];
        bus(1'h1, `ADDR_CTRL, c);
        bus(1'h1, `ADDR_DATA, v);
        repeat (6) @(posedge clk);
        for (k = 0; k < 11; k++)
        begin
            chk(txd, fr[k]);
            repeat (16) @(posedge clk);
        end
    end
    endtask
    initial
    begin
        @(posedge clk);
        for (i = 3; i >= 0; i--)
        begin
            p0 <= i[1];
            p1 <= i[0];
            do_reset;
            chk(bm, i[1:0]);
            chk(cb, i != 0);
            chk(sa, `START_ADDR);
            bus(1'h0, `ADDR_DIV, 0);
            chk(q, i == 3 ? `BOOT_DIV : `DIV_RESET);
        end
        bus(1'h0, `ADDR_CTRL, 0);
        chk(q, `CTL_RESET);
        bus(1'h0, 4'h2, 0);
        chk(q, 0);
        for (i = 0; i < 3; i++)
            tx_async(ctl_t[i], val_t[i]);
        bus(1'h1, `ADDR_CTRL, 10'h008);
        peer.send_async(9'h15A);
        repeat (4) @(posedge clk);
        bus(1'h0, `ADDR_DATA, 0);
        chk(q[8:0], 9'h15A);
        for (i = 0; i < 2; i++)
        begin
            bus(1'h1, `ADDR_CTRL, i << 6);
            pulse(i[0], !i[0], 1'h1);
            pulse(!i[0], i[0], 1'h0);
        end
        for (i = 0; i < 2; i++)
        begin
            bus(1'h1, `ADDR_CTRL, 10'h080 | (i << 8));
            repeat (2) @(posedge clk);
            chk(st_n, i[0]);
            peer.level(i[0]);
            repeat (4) @(posedge clk);
            bus(1'h0, `ADDR_STAT, 0);
            chk(q[3], i[0]);
        end
        bus(1'h1, `ADDR_CTRL, 10'h001);
        bus(1'h1, `ADDR_DATA, 9'h0A5);
        do
            bus(1'h0, `ADDR_STAT, 0);
        while (q[0] !== 1'h0);
        chk(got, 8'hA5);
        bus(1'h1, `ADDR_CTRL, 10'h011);
        peer.send_sync(8'h3C);
        repeat (4) @(posedge clk);
        bus(1'h0, `ADDR_DATA, 0);
        chk(q[7:0], 8'h3C);
        chk(oe_n, 1'h1);
        bus(1'h1, `ADDR_CTRL, 10'h022);
        bus(1'h1, `ADDR_DATA, 10'h200);
        @(posedge clk);
        chk(irda, 1'h1);
        repeat (4) @(posedge clk);
        chk(irda, 1'h0);
        for (i = 0; i < 8; i++)
        begin
            repeat (i == 0 ? 2 : 16) @(posedge clk);
            chk(txd, fl[i]);
        end
        repeat (10) @(posedge clk);
        bus(1'h1, `ADDR_CTRL, 0);
        bus(1'h1, `ADDR_DATA, 0);
        repeat (40) @(posedge clk);
        nrst <= 1'h0;
        repeat (2) @(posedge clk);
        chk(txd, 1'h1);
        do_reset;
        end_sim;
    end
endmodule // tb_top
